// ---- dv/mmd_decoder_checker.sv ----
`include "mmd_map.svh"
module mmd_decoder_checker
  import mmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // stimulus seen
  input wire logic locked,
  input wire logic chip_erase,
  input wire mmd_req_s cpu_req,
  input wire mmd_req_s dbg_req,
  input wire mmd_req_s crc_req,
  // results seen
  input wire logic cpu_ack,
  input wire logic cpu_stall,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_skip,
  input wire logic dbg_ack,
  input wire logic [7:0] dbg_rdata,
  input wire logic crc_ack,
  input wire logic nv_wr,
  input wire logic [15:0] nv_addr,
  input wire logic [7:0] nv_data
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence cpu_flash_s;
    cpu_req.valid && cpu_req.op == mmd_op_pmload;
  endsequence
  sequence crc_take_s;
    crc_req.valid;
  endsequence
  io_single_a: assert property (cpu_req.valid && cpu_req.op == mmd_op_io |=> cpu_ack)
    else $error("io access not answered next cycle");
  crc_first_a: assert property (crc_take_s ##0 cpu_flash_s |=> crc_ack && cpu_stall && !cpu_ack)
    else $error("crc did not win flash");
  idle_quiet_a: assert property (!cpu_req.valid |=> !cpu_ack)
    else $error("ack without request");
  sig_read_a: assert property (dbg_req.valid && dbg_req.op == mmd_op_sig && dbg_req.addr == 16'h0002
    && !dbg_req.write |=> dbg_ack && dbg_rdata == `MMD_SIG2) else $error("id byte wrong");
  hi_bit_a: assert property (cpu_req.valid && cpu_req.op == mmd_op_bittest && cpu_req.addr > 16'h001F
    |=> !cpu_skip) else $error("bit test above bit range");
  unmapped_a: assert property (cpu_req.valid && cpu_req.op == mmd_op_data && cpu_req.addr[15:12] == 4'h1
    && cpu_req.addr[11:8] < 4'h3 |=> !nv_wr && cpu_rdata == 8'h00) else $error("unmapped access had effect");
  eep_hand_a: assert property (cpu_req.valid && cpu_req.op == mmd_op_data && cpu_req.write && !chip_erase
    && cpu_req.addr == 16'h1400 |=> nv_wr && nv_addr == 16'h1400 && nv_data == $past(cpu_req.wdata))
    else $error("eeprom write not handed over");
  usr_lock_a: assert property (dbg_req.valid && dbg_req.op == mmd_op_data && dbg_req.write && locked
    && dbg_req.addr[15:5] == 11'h098 |=> nv_wr) else $error("locked user page write refused");
endmodule : mmd_decoder_checker

bind mmd_decoder mmd_decoder_checker u_chk (.clk, .rstn, .locked, .chip_erase, .cpu_req, .dbg_req, .crc_req,
  .cpu_ack, .cpu_stall, .cpu_rdata, .cpu_skip, .dbg_ack, .dbg_rdata, .crc_ack, .nv_wr, .nv_addr, .nv_data);

// ---- dv/mmd_flash_model.sv ----
module mmd_flash_model
(
  // flash word port
  input wire logic [11:0] fl_word_addr,
  output logic [15:0] fl_word_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // high byte is word address bits 11:4 xored with 0xC3, low byte is word address bits 7:0
  assign fl_word_data = {fl_word_addr[11:4] ^ 8'hC3, fl_word_addr[7:0]};
endmodule : mmd_flash_model

// ---- dv/tb.sv ----
`include "mmd_map.svh"
module tb
  import mmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, locked, chip_erase, cpu_ack, cpu_stall, cpu_skip, dbg_ack, crc_ack, nv_wr, nv, skp;
  logic [7:0] bep, aep, flag_set, cpu_rdata, dbg_rdata, flags, nv_data, rd;
  logic [15:0] nv_addr, fl_word_data;
  logic [11:0] fl_word_addr;
  mmd_size_e size_sel;
  mmd_req_s cpu_req, dbg_req, crc_req;
  int bad_count, compares, cyc;
  mmd_decoder uut (.clk, .rstn, .size_sel, .locked, .boot_end_page(bep), .app_end_page(aep), .chip_erase,
    .cpu_req, .dbg_req, .crc_req, .flag_set, .cpu_ack, .cpu_stall, .cpu_rdata, .cpu_skip, .dbg_ack,
    .dbg_rdata, .crc_ack, .crc_rdata(), .flags, .nv_wr, .nv_addr, .nv_data, .fl_word_addr, .fl_word_data);
  mmd_flash_model u_fl (.fl_word_addr, .fl_word_data);
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      final_report;
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task final_report;
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] fe(input logic [15:0] o);
    logic [11:0] w;
    w = o[12:1];
    return o[0] ? w[11:4] ^ 8'hC3 : w[7:0];
  endfunction : fe
  task automatic acc(input logic dbg, input mmd_op_e op, input logic [15:0] a, input logic w,
    input logic [7:0] d, input logic [2:0] b);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    if (dbg)
      dbg_req = '{1'h1, op, a, w, d, b};
    else
      cpu_req = '{1'h1, op, a, w, d, b};
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while ((dbg ? dbg_ack : cpu_ack) !== 1'h1 && n < 20);
    check("ack", dbg ? dbg_ack : cpu_ack, 16'h0001);
    rd = dbg ? dbg_rdata : cpu_rdata;
    nv = nv_wr;
    skp = cpu_skip;
    cpu_req.valid = 1'h0;
    dbg_req.valid = 1'h0;
  endtask : acc
  task automatic rio(input logic [15:0] a);
    acc(0, mmd_op_io, a, 0, 8'h00, 3'h0);
  endtask : rio
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_gs;
    for (int i = 0; i < 4; i++)
    begin
      rio(16'h001C + i);
      check("gs_reset", rd, 16'h0000);
      acc(0, mmd_op_io, 16'h001C + i, 1, 8'h11 * (i + 1), 3'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      acc(0, mmd_op_data, 16'h001C + i, 0, 8'h00, 3'h0);
      check("gs_rw", rd, 8'h11 * (i + 1));
    end
    acc(0, mmd_op_bitset, 16'h001C, 0, 8'h00, 3'h7);
    acc(0, mmd_op_bitclr, 16'h001C, 0, 8'h00, 3'h0);
    rio(16'h001C);
    check("gs_bits", rd, 16'h0090);
    acc(0, mmd_op_bittest, 16'h001F, 0, 8'h01, 3'h2);
    check("skip_low", skp, 16'h0001);
    acc(0, mmd_op_bittest, 16'h003F, 0, 8'h00, 3'h2);
    check("skip_high", skp, 16'h0000);
  endtask : t_gs
  task t_flags;
    @(posedge clk);
    #1 flag_set = 8'h0F;
    @(posedge clk);
    #1 flag_set = 8'h00;
    acc(0, mmd_op_io, 16'h0000, 1, 8'h05, 3'h0);
    rio(16'h0000);
    check("w1c", rd, 16'h000A);
    acc(0, mmd_op_bitset, 16'h0000, 0, 8'h00, 3'h1);
    acc(0, mmd_op_bitclr, 16'h0000, 0, 8'h00, 3'h3);
    rio(16'h0000);
    check("bit_w1c", rd, 16'h0008);
    check("flags", flags, 16'h0008);
  endtask : t_flags
  task t_flash;
    for (int s = 0; s < 3; s++)
    begin
      size_sel = mmd_size_e'(s);
      acc(0, mmd_op_data, 16'h8000 + (16'h0800 << s) - 1, 0, 8'h00, 3'h0);
      check("fl_last", rd, fe((16'h0800 << s) - 1));
      acc(0, mmd_op_data, 16'h8000 + (16'h0800 << s), 0, 8'h00, 3'h0);
      check("fl_out", rd, 16'h0000);
      acc(0, mmd_op_pmload, 16'h0005, 0, 8'h00, 3'h0);
      check("fl_pm", rd, fe(16'h0005));
      acc(0, mmd_op_data, 16'h8004, 0, 8'h00, 3'h0);
      check("fl_data", rd, fe(16'h0004));
      acc(0, mmd_op_data, 16'h4000 - (16'h0080 << s), 1, 8'h6B, 3'h0);
      acc(0, mmd_op_data, 16'h4000 - (16'h0080 << s), 0, 8'h00, 3'h0);
      check("sram", rd, 16'h006B);
      acc(0, mmd_op_data, 16'h3FFF - (16'h0080 << s), 0, 8'h00, 3'h0);
      check("sram_below", rd, 16'h0000);
    end
  endtask : t_flash
  task t_nv;
    acc(0, mmd_op_data, 16'h1400, 1, 8'h3C, 3'h0);
    check("eep_wr", {nv, nv_addr[7:0]}, 16'h0100);
    size_sel = mmd_flash_2k;
    acc(0, mmd_op_data, 16'h1440, 1, 8'h3C, 3'h0);
    check("eep_out", nv, 16'h0000);
    acc(0, mmd_op_data, 16'h1000, 1, 8'h3C, 3'h0);
    locked = 1'h1;
    acc(1, mmd_op_data, 16'h1300, 1, 8'h77, 3'h0);
    check("usr_lock", nv, 16'h0001);
    acc(1, mmd_op_data, 16'h1400, 1, 8'h77, 3'h0);
    check("eep_lock", nv, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      acc(1, mmd_op_sig, i, 0, 8'h00, 3'h0);
      check("sig", rd, i == 0 ? `MMD_SIG0 : i == 1 ? `MMD_SIG1 : `MMD_SIG2);
    end
    chip_erase = 1'h1;
    acc(0, mmd_op_data, 16'h131F, 1, 8'h12, 3'h0);
    check("usr_erase", nv, 16'h0001);
    chip_erase = 1'h0;
    locked = 1'h0;
    bep = 8'h02;
    aep = 8'h08;
    for (int p = 1; p < 11; p += 3)
    begin
      acc(0, mmd_op_data, 16'h8000 + 16'h0040 * p, 1, 8'h01, 3'h0);
      check("section", nv, 16'(p < 2 || p >= 8));
    end
  endtask : t_nv
  task t_crc;
    fork
      acc(0, mmd_op_pmload, 16'h0010, 0, 8'h00, 3'h0);
      begin
        @(posedge clk);
        #1 crc_req = '{1'h1, mmd_op_pmload, 16'h0020, 1'h0, 8'h00, 3'h0};
        @(posedge clk);
        #1 crc_req.valid = 1'h0;
        check("crc_win", {crc_ack, cpu_stall}, 16'h0003);
      end
    join
    check("crc_cpu", rd, fe(16'h0010));
  endtask : t_crc
  initial
  begin
    clk = 1'h0;
    rstn = 1'h0;
    size_sel = mmd_flash_8k;
    {locked, chip_erase, bep, aep, flag_set, cyc} = '0;
    {cpu_req, dbg_req, crc_req} = '0;
    repeat (8) @(posedge clk);
    #1 rstn = 1'h1;
    t_gs;
    t_flags;
    t_flash;
    t_nv;
    t_crc;
    final_report;
  end
endmodule : tb

// ---- hdl/mmd_decoder.sv ----
// Operation
// - data loads see flash from 0x8000
// - program-memory load addresses flash from zero
// - flash in 64-byte pages, 32/64/128
// - SRAM ends at region top, size-dependent start
// - EEPROM at 0x1400, 32-byte pages
// - EEPROM bytes readable, writes go to controller
// - user settings page, cpu and unlocked debug
// - debug may write user page when locked
// - chip erase leaves user page alone
// - three id bytes, readable when locked
// - short I/O 0x00-0x3F single cycle
// - extended I/O only via data loads/stores
// - bit ops and tests only 0x00-0x1F
// - bit ops touch only the addressed bit
// - write-one-to-clear flags ignore zeros
// - general store at I/O 0x1C-0x1F
// - general store bytes RW, reset zero
// - crc scanner reads flash, competes with cpu
// - flash boot/app/data sections, write guarded
// - program counter 10, 11 or 12 bits
// - flash organised as 16-bit words
`include "mmd_map.svh"
module mmd_decoder
  import mmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input wire mmd_size_e size_sel,
  input wire logic locked,
  input wire logic [7:0] boot_end_page,
  input wire logic [7:0] app_end_page,
  input wire logic chip_erase,
  // masters
  input wire mmd_req_s cpu_req,
  input wire mmd_req_s dbg_req,
  input wire mmd_req_s crc_req,
  // short I/O address 0x00 peripheral flags (w1c block)
  input wire logic [7:0] flag_set,
  // results
  output logic cpu_ack,
  output logic cpu_stall,
  output logic [7:0] cpu_rdata,
  output logic cpu_skip,
  output logic dbg_ack,
  output logic [7:0] dbg_rdata,
  output logic crc_ack,
  output logic [15:0] crc_rdata,
  output logic [7:0] flags,
  // nonvolatile controller handoff
  output logic nv_wr,
  output logic [15:0] nv_addr,
  output logic [7:0] nv_data,
  // flash word port
  output logic [11:0] fl_word_addr,
  input wire logic [15:0] fl_word_data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] sram_mem [0:511];
  logic [7:0] eep_mem [0:127];
  logic [7:0] usr_mem [0:`MMD_USR_SIZE-1];
  logic [3:0][7:0] gs;
  logic [1:0] gs_idx;
  logic gs_wr;
  logic [7:0] gs_wdata;
  logic [7:0] flags_q;
  logic [15:0] sram_base;
  logic [15:0] flash_bytes;
  logic [7:0] eep_bytes;
  logic [3:0] pc_bits;
  // ----------------------------------------
  // size decode
  // ----------------------------------------
  always_comb
  begin
    case (size_sel)
      mmd_flash_2k:
      begin
        sram_base = `MMD_SRAM_BASE_S;
        flash_bytes = 16'(32 * `MMD_FLASH_PAGE);
        eep_bytes = 8'(2 * `MMD_EEP_PAGE);
        pc_bits = 4'd10;
      end
      mmd_flash_4k:
      begin
        sram_base = `MMD_SRAM_BASE_M;
        flash_bytes = 16'(64 * `MMD_FLASH_PAGE);
        eep_bytes = 8'(4 * `MMD_EEP_PAGE);
        pc_bits = 4'd11;
      end
      default:
      begin
        sram_base = `MMD_SRAM_BASE_L;
        flash_bytes = 16'(128 * `MMD_FLASH_PAGE);
        eep_bytes = 8'(4 * `MMD_EEP_PAGE);
        pc_bits = 4'd12;
      end
    endcase
  end
  // ----------------------------------------
  // region decode
  // ----------------------------------------
  function automatic mmd_reg_e decode(input mmd_req_s r, input logic [15:0] sb,
                                      input logic [15:0] fb, input logic [7:0] eb);
    mmd_reg_e res;
    res = mmd_reg_none;
    case (r.op)
      mmd_op_io, mmd_op_bitset, mmd_op_bitclr, mmd_op_bittest:
      begin
        if (r.addr <= `MMD_IO_LAST)
        begin
          if (r.op != mmd_op_io && r.addr > `MMD_BITIO_LAST)
            res = mmd_reg_none;
          else if (r.addr >= `MMD_GS_BASE && r.addr <= `MMD_BITIO_LAST)
            res = mmd_reg_gs;
          else
            res = mmd_reg_io;
        end
      end
      mmd_op_pmload:
        if (r.addr - `MMD_FLASH_PBASE < fb)
          res = mmd_reg_flash;
      mmd_op_sig:
        if (r.addr < 16'(`MMD_SIG_SIZE))
          res = mmd_reg_sig;
      mmd_op_data:
      begin
        if (r.addr >= `MMD_FLASH_DBASE && r.addr - `MMD_FLASH_DBASE < fb)
          res = mmd_reg_flash;
        else if (r.addr >= sb && r.addr < `MMD_SRAM_TOP)
          res = mmd_reg_sram;
        else if (r.addr >= `MMD_EEP_BASE && r.addr < `MMD_EEP_BASE + 16'(eb))
          res = mmd_reg_eep;
        else if (r.addr >= `MMD_USR_BASE && r.addr < `MMD_USR_BASE + 16'(`MMD_USR_SIZE))
          res = mmd_reg_usr;
        else if (r.addr >= `MMD_GS_BASE && r.addr <= `MMD_BITIO_LAST)
          res = mmd_reg_gs;
        else if (r.addr <= `MMD_EXTIO_LAST)
          res = mmd_reg_io;
      end
      default:
        res = mmd_reg_none;
    endcase
    return res;
  endfunction : decode
  mmd_reg_e cpu_reg;
  mmd_reg_e dbg_reg;
  logic crc_hit;
  logic cpu_fl;
  logic cpu_go;
  logic dbg_ok;
  logic [7:0] page_of;
  logic write_allowed;
  logic cpu_nv;
  logic usr_dbg_wr;
  logic fl_ready;
  always_comb
  begin
    cpu_reg = decode(cpu_req, sram_base, flash_bytes, eep_bytes);
    dbg_reg = decode(dbg_req, sram_base, flash_bytes, eep_bytes);
    crc_hit = crc_req.valid && crc_req.op == mmd_op_pmload && crc_req.addr < flash_bytes;
    cpu_fl = cpu_req.valid && cpu_reg == mmd_reg_flash;
    // locked debug reaches only the id bytes and the user page
    dbg_ok = dbg_req.valid && (!locked || dbg_reg == mmd_reg_sig ||
             (dbg_reg == mmd_reg_usr && dbg_req.write));
    usr_dbg_wr = dbg_ok && dbg_reg == mmd_reg_usr && dbg_req.write;
    page_of = 8'(cpu_req.addr[13:6]);
    // boot section writable; app code locked below app_end
    write_allowed = page_of >= app_end_page || page_of < boot_end_page;
    cpu_nv = cpu_req.write && (cpu_reg == mmd_reg_eep || cpu_reg == mmd_reg_usr ||
             (cpu_reg == mmd_reg_flash && write_allowed));
    // crc owns the flash port first; a flash read also waits for its word
    cpu_go = cpu_req.valid && !(cpu_fl && (crc_hit || (!cpu_req.write && !fl_ready))) &&
             !(usr_dbg_wr && cpu_nv);
  end
  // ----------------------------------------
  // flash port
  // ----------------------------------------
  logic [15:0] fl_byte;
  always_comb
  begin
    if (crc_hit)
      fl_byte = crc_req.addr;
    else if (cpu_req.op == mmd_op_data)
      fl_byte = cpu_req.addr - `MMD_FLASH_DBASE;
    else
      fl_byte = cpu_req.addr;
    // registered word address already holds the wanted word
    fl_ready = fl_word_addr == (fl_byte[12:1] & 12'((1 << pc_bits) - 1));
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fl_word_addr <= '0;
    else
      fl_word_addr <= fl_byte[12:1] & 12'((1 << pc_bits) - 1);
  end
  // ----------------------------------------
  // general store and flag block
  // ----------------------------------------
  logic [7:0] cur_byte;
  always_comb
  begin
    gs_idx = cpu_req.addr[1:0];
    gs_wr = 1'b0;
    gs_wdata = gs[gs_idx];
    if (cpu_go && cpu_reg == mmd_reg_gs)
    begin
      if (cpu_req.op == mmd_op_bitset)
      begin
        gs_wr = 1'b1;
        gs_wdata = gs[gs_idx] | (8'h01 << cpu_req.bit_sel);
      end
      else if (cpu_req.op == mmd_op_bitclr)
      begin
        gs_wr = 1'b1;
        gs_wdata = gs[gs_idx] & ~(8'h01 << cpu_req.bit_sel);
      end
      else if (cpu_req.write)
      begin
        gs_wr = 1'b1;
        gs_wdata = cpu_req.wdata;
      end
    end
  end
  mmd_gstore u_gstore (
    .clk(clk),
    .rstn(rstn),
    .idx(gs_idx),
    .wr(gs_wr),
    .wdata(gs_wdata),
    .store(gs)
  );
  logic [7:0] flag_clr;
  always_comb
  begin
    flag_clr = 8'h00;
    if (cpu_go && cpu_reg == mmd_reg_io && cpu_req.addr == 16'h0000)
    begin
      if (cpu_req.op == mmd_op_bitset)
        flag_clr = 8'h01 << cpu_req.bit_sel;
      else if (cpu_req.op != mmd_op_bitclr && cpu_req.write)
        flag_clr = cpu_req.wdata;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      flags_q <= 8'h00;
    else
      flags_q <= (flags_q & ~flag_clr) | flag_set;
  end
  // ----------------------------------------
  // memories
  // ----------------------------------------
  logic [8:0] sram_idx;
  logic [6:0] eep_idx;
  logic [4:0] usr_idx;
  always_comb
  begin
    sram_idx = 9'(cpu_req.addr - sram_base);
    eep_idx = 7'(cpu_req.addr - `MMD_EEP_BASE);
    usr_idx = usr_dbg_wr ? 5'(dbg_req.addr - `MMD_USR_BASE) : 5'(cpu_req.addr - `MMD_USR_BASE);
  end
  always_ff @(posedge clk)
  begin
    if (cpu_go && cpu_reg == mmd_reg_sram && cpu_req.write)
      sram_mem[sram_idx] <= cpu_req.wdata;
  end
  // user page writes are never touched by chip erase
  always_ff @(posedge clk)
  begin
    if (usr_dbg_wr)
      usr_mem[usr_idx] <= dbg_req.wdata;
    else if (cpu_go && cpu_reg == mmd_reg_usr && cpu_req.write)
      usr_mem[usr_idx] <= cpu_req.wdata;
  end
  // eeprom mirror updated here; programming owned by controller
  always_ff @(posedge clk)
  begin
    if (cpu_go && cpu_reg == mmd_reg_eep && cpu_req.write && !chip_erase)
      eep_mem[eep_idx] <= cpu_req.wdata;
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      nv_wr <= 1'b0;
      nv_addr <= 16'h0000;
      nv_data <= 8'h00;
    end
    else
    begin
      // debug user-page writes take the controller port first
      nv_wr <= usr_dbg_wr || (cpu_go && cpu_nv);
      nv_addr <= usr_dbg_wr ? dbg_req.addr : cpu_req.addr;
      nv_data <= usr_dbg_wr ? dbg_req.wdata : cpu_req.wdata;
    end
  end
  // ----------------------------------------
  // read data
  // ----------------------------------------
  function automatic logic [7:0] sig_byte(input logic [1:0] a);
    case (a)
      2'd0: return `MMD_SIG0;
      2'd1: return `MMD_SIG1;
      2'd2: return `MMD_SIG2;
      default: return 8'h00;
    endcase
  endfunction : sig_byte
  always_comb
  begin
    case (cpu_reg)
      mmd_reg_sram: cur_byte = sram_mem[sram_idx];
      mmd_reg_eep: cur_byte = eep_mem[eep_idx];
      mmd_reg_usr: cur_byte = usr_mem[usr_idx];
      mmd_reg_gs: cur_byte = gs[gs_idx];
      mmd_reg_sig: cur_byte = sig_byte(cpu_req.addr[1:0]);
      mmd_reg_io: cur_byte = cpu_req.addr == 16'h0000 ? flags_q : 8'h00;
      mmd_reg_flash: cur_byte = fl_byte[0] ? fl_word_data[15:8] : fl_word_data[7:0];
      default: cur_byte = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpu_ack <= 1'b0;
      cpu_stall <= 1'b0;
      cpu_rdata <= 8'h00;
      cpu_skip <= 1'b0;
    end
    else
    begin
      cpu_ack <= cpu_go;
      cpu_stall <= cpu_req.valid && !cpu_go;
      cpu_rdata <= (cpu_go && !cpu_req.write) ? cur_byte : 8'h00;
      cpu_skip <= cpu_go && cpu_req.op == mmd_op_bittest && cpu_reg != mmd_reg_none &&
                  (cur_byte[cpu_req.bit_sel] == cpu_req.wdata[0]);
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dbg_ack <= 1'b0;
      dbg_rdata <= 8'h00;
      crc_ack <= 1'b0;
      crc_rdata <= 16'h0000;
      flags <= 8'h00;
    end
    else
    begin
      dbg_ack <= dbg_req.valid;
      dbg_rdata <= (dbg_ok && dbg_reg == mmd_reg_sig) ? sig_byte(dbg_req.addr[1:0]) : 8'h00;
      crc_ack <= crc_hit;
      crc_rdata <= fl_word_data;
      flags <= flags_q;
    end
  end
endmodule : mmd_decoder

// ---- hdl/mmd_gstore.sv ----
`include "mmd_map.svh"
module mmd_gstore
  import mmd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // byte access
  input wire logic [1:0] idx,
  input wire logic wr,
  input wire logic [7:0] wdata,
  // contents
  output logic [3:0][7:0] store
);
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_store
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          store[g] <= `MMD_GS_RESET;
        else if (wr && idx == 2'(g))
          store[g] <= wdata;
      end
    end
  endgenerate
endmodule : mmd_gstore

// ---- pkg/mmd_map.svh ----
`ifndef MMD_MAP_SVH
`define MMD_MAP_SVH
// data-space bases
`define MMD_FLASH_DBASE 16'h8000
`define MMD_FLASH_PBASE 16'h0000
`define MMD_EEP_BASE 16'h1400
`define MMD_USR_BASE 16'h1300
`define MMD_SRAM_TOP 16'h4000
`define MMD_SRAM_BASE_S 16'h3F80
`define MMD_SRAM_BASE_M 16'h3F00
`define MMD_SRAM_BASE_L 16'h3E00
`define MMD_IO_LAST 16'h003F
`define MMD_BITIO_LAST 16'h001F
`define MMD_EXTIO_LAST 16'h0FFF
// sizes
`define MMD_FLASH_PAGE 64
`define MMD_EEP_PAGE 32
`define MMD_USR_SIZE 32
`define MMD_SIG_SIZE 3
// general store block
`define MMD_GS_BASE 16'h001C
`define MMD_GS_RESET 8'h00
// identity, arbitrary values
`define MMD_SIG0 8'hA5
`define MMD_SIG1 8'h5A
`define MMD_SIG2 8'h3C
`endif

// ---- pkg/mmd_pkg.sv ----
package mmd_pkg;
  typedef enum logic [2:0] {
    mmd_op_none,
    mmd_op_io,
    mmd_op_data,
    mmd_op_pmload,
    mmd_op_bitset,
    mmd_op_bitclr,
    mmd_op_bittest,
    mmd_op_sig
  } mmd_op_e;
  typedef enum logic [1:0] {
    mmd_src_cpu,
    mmd_src_dbg,
    mmd_src_crc
  } mmd_src_e;
  typedef enum logic [3:0] {
    mmd_reg_none,
    mmd_reg_flash,
    mmd_reg_sram,
    mmd_reg_eep,
    mmd_reg_usr,
    mmd_reg_io,
    mmd_reg_gs,
    mmd_reg_sig
  } mmd_reg_e;
  typedef struct packed {
    logic valid;
    mmd_op_e op;
    logic [15:0] addr;
    logic write;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } mmd_req_s;
  typedef enum logic [1:0] {
    mmd_flash_2k,
    mmd_flash_4k,
    mmd_flash_8k
  } mmd_size_e;
endpackage : mmd_pkg
